// ===== inc/hdtas_pkg.sv
// constants and carriers for the hdlc timer, address and status bank
// Operation
// - base period is k times value plus one
// - internal mode sends up to six retries
// - retry count seven means unlimited retries
// - external mode interrupt after extension plus base
// - external count seven gives periodic interrupt
// - two-byte mode device drives c/r bit
// - one-byte mode: first command, second response
// - transmit addresses used in auto-mode only
// - twelve-bit received byte count, read per frame
// - high byte compared with programmed and group
// - match codes 10, 00, 01; first wins
// - report received c/r bit as received
// - modulo select chooses modulo 8 or 128
// - misaligned or short frames marked invalid
// - overflow flagged when frame data lost
// - checksum result and abort reported
// - low byte matched against first low value only
// - status byte appended to receive queue
// - transparent modes expose early frame byte
// - extended transparent exposes last complete byte
// - start command starts, timer write stops
`default_nettype none
package hdtas_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_COMMAND = 8'h21;
  localparam logic [7:0] IDX_MODE = 8'h22;
  localparam logic [7:0] IDX_TIMER = 8'h23;
  localparam logic [7:0] IDX_TX_ADDR1 = 8'h24;
  localparam logic [7:0] IDX_RX_COUNT_LO = 8'h25;
  localparam logic [7:0] IDX_RX_HIGH1 = 8'h26;
  localparam logic [7:0] IDX_RX_HIGH2 = 8'h27;
  localparam logic [7:0] IDX_RX_STATUS = 8'h27;
  localparam logic [7:0] IDX_RX_LOW1 = 8'h28;
  localparam logic [7:0] IDX_RX_LOW2 = 8'h29;
  localparam logic [7:0] IDX_TX_ADDR2 = 8'h2A;
  localparam logic [7:0] IDX_RX_COUNT_HI = 8'h2D;
  localparam int CMD_START_BIT = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] K_FINE = 16'h8000;
  localparam logic [15:0] K_COARSE = 16'h0200;
  localparam logic [2:0] COUNT_UNLIMITED = 3'h7;
  localparam logic [7:0] GROUP_ADDR_A = 8'hFE;
  localparam logic [7:0] GROUP_ADDR_B = 8'hFC;
  localparam logic [11:0] MIN_LEN_WIDE = 12'h004;
  localparam logic [11:0] MIN_LEN_NARROW = 12'h003;
  localparam logic [11:0] MIN_LEN_TRANSP0 = 12'h002;
  localparam logic [11:0] COUNT_MAX = 12'hFFF;
  localparam logic [1:0] MATCH_FIRST = 2'b10;
  localparam logic [1:0] MATCH_SECOND = 2'b00;
  localparam logic [1:0] MATCH_GROUP = 2'b01;
  localparam logic [1:0] MATCH_NONE = 2'b11;
  typedef enum logic [1:0] {
    HDTAS_AUTO = 2'b00,
    HDTAS_NONAUTO = 2'b01,
    HDTAS_TRANSP = 2'b10,
    HDTAS_EXT_TRANSP = 2'b11
  } hdtas_mode_type;
  typedef struct packed {
    logic [2:0] retry_or_extension_count;
    logic [4:0] period;
  } hdtas_timer_type;
  typedef struct packed {
    logic frame_valid;
    logic rx_overflow;
    logic crc_ok;
    logic rx_aborted;
    logic high_match_code_msb;
    logic high_match_code_lsb;
    logic cr_bit;
    logic low_match;
  } hdtas_status_type;
endpackage
`default_nettype wire

// ===== hw/hdtas_regs.sv
// register bank with protocol timer, address and receive status logic
`timescale 1ns/1ps
`default_nettype none
module hdtas_regs (
  input wire logic pclk, // bus clock, 20 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic tx_clk_pin, // transmit data clock pin
  input wire logic rx_clk_pin, // receive clock pin
  input wire logic rx_data_pin, // receive data pin
  input wire logic iframe_unacked, // an i-frame awaits acknowledge
  input wire logic tx_is_command, // frame being sent is a command
  input wire logic rx_byte_valid, // receiver byte strobe
  input wire logic [7:0] rx_byte, // receiver byte
  input wire logic rx_frame_end, // closing flag or abort seen
  input wire logic rx_bits_aligned, // frame was whole bytes
  input wire logic rx_crc_ok, // checksum good
  input wire logic rx_abort, // frame aborted by sender
  input wire logic rx_data_lost, // receiver dropped data
  output logic [7:0] tx_addr_high, // first address byte to send
  output logic [7:0] tx_addr_low, // second address byte to send
  output logic tx_addr_insert, // address bytes are appended
  output logic modulo_select, // 1 = modulo 128 control field
  output logic command_interpretation, // c/r sense setting
  output logic timer_irq, // timer interrupt pulse
  output logic supervisory_request, // send s-command pulse
  output logic retry_exhausted, // retries used up pulse
  output logic timer_running, // timer active level
  output logic receive_queue_valid, // queue write strobe
  output logic [7:0] receive_queue_data // queue write byte
);
  import hdtas_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [2:0] tx_clk_sync;
  logic [2:0] rx_clk_sync;
  logic [1:0] rx_data_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_clk_sync <= 3'h0;
      rx_clk_sync <= 3'h0;
      rx_data_sync <= 2'h0;
    end else begin
      tx_clk_sync <= {tx_clk_sync[1:0], tx_clk_pin};
      rx_clk_sync <= {rx_clk_sync[1:0], rx_clk_pin};
      rx_data_sync <= {rx_data_sync[0], rx_data_pin};
    end
  end
  logic tx_tick;
  logic rx_tick;
  assign tx_tick = tx_clk_sync[1] & ~tx_clk_sync[2];
  assign rx_tick = rx_clk_sync[1] & ~rx_clk_sync[2];

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic [7:0] idx;
  logic setup;
  logic wr;
  logic hit;
  assign idx = paddr[9:2];
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  always_comb begin
    if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (idx >= IDX_COMMAND && idx <= IDX_TX_ADDR2) begin
      hit = 1'b1;
    end else if (idx == IDX_RX_COUNT_HI) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end
  assign pslverr = psel & penable & ~hit;

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  hdtas_timer_type protocol_timer;
  logic [7:0] mode_reg;
  logic [7:0] tx_address_first;
  logic [7:0] tx_address_second;
  logic [7:0] rx_high_address_first;
  logic [7:0] rx_high_address_second;
  logic [7:0] rx_low_address_first;
  logic [7:0] rx_low_address_second;
  logic start_timer_command;
  logic timer_write;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protocol_timer <= RESET_BYTE;
      mode_reg <= RESET_BYTE;
      tx_address_first <= RESET_BYTE;
      tx_address_second <= RESET_BYTE;
      rx_high_address_first <= RESET_BYTE;
      rx_high_address_second <= RESET_BYTE;
      rx_low_address_first <= RESET_BYTE;
      rx_low_address_second <= RESET_BYTE;
    end else if (wr && hit && paddr[11:10] == 2'b00) begin
      if (idx == IDX_MODE) begin
        mode_reg <= pwdata[7:0];
      end else if (idx == IDX_TIMER) begin
        protocol_timer <= pwdata[7:0];
      end else if (idx == IDX_TX_ADDR1) begin
        tx_address_first <= pwdata[7:0];
      end else if (idx == IDX_TX_ADDR2) begin
        tx_address_second <= pwdata[7:0];
      end else if (idx == IDX_RX_HIGH1) begin
        rx_high_address_first <= pwdata[7:0];
      end else if (idx == IDX_RX_HIGH2) begin
        rx_high_address_second <= pwdata[7:0];
      end else if (idx == IDX_RX_LOW1) begin
        rx_low_address_first <= pwdata[7:0];
      end else if (idx == IDX_RX_LOW2) begin
        rx_low_address_second <= pwdata[7:0];
      end
    end
  end
  assign start_timer_command = wr && idx == IDX_COMMAND &&
    paddr[11:10] == 2'b00 && pwdata[CMD_START_BIT];
  assign timer_write = wr && idx == IDX_TIMER && paddr[11:10] == 2'b00;

  hdtas_mode_type op_mode;
  logic address_width_select;
  logic timer_source_select;
  logic timer_resolution;
  assign op_mode = hdtas_mode_type'(mode_reg[7:6]);
  assign address_width_select = mode_reg[5];
  assign timer_source_select = mode_reg[4];
  assign timer_resolution = mode_reg[1];
  assign command_interpretation = rx_high_address_first[1];
  assign modulo_select = rx_high_address_second[1];

  // ------------------------------------------------------------
  // transmit address insertion
  // ------------------------------------------------------------
  logic cr_out;
  // software leaves bit 1 at zero; it is overwritten here
  assign cr_out = tx_is_command ~^ command_interpretation;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_addr_high <= RESET_BYTE;
      tx_addr_low <= RESET_BYTE;
      tx_addr_insert <= 1'b0;
    end else begin
      tx_addr_insert <= op_mode == HDTAS_AUTO;
      if (address_width_select) begin
        tx_addr_high <= {tx_address_first[7:2], cr_out,
          tx_address_first[0]};
        tx_addr_low <= tx_address_second;
      end else begin
        tx_addr_high <= tx_is_command ? tx_address_first :
          tx_address_second;
        tx_addr_low <= RESET_BYTE;
      end
    end
  end

  // ------------------------------------------------------------
  // protocol timer, stepped by transmit clock edges
  // ------------------------------------------------------------
  logic [15:0] prescale;
  logic [7:0] units;
  logic [7:0] unit_target;
  logic [2:0] retries;
  logic ext_phase;
  logic unacked_q;
  logic start_evt;
  logic stop_evt;
  logic [15:0] k_factor;
  logic expiry;
  logic [2:0] tcount;
  assign tcount = protocol_timer.retry_or_extension_count;
  assign k_factor = timer_resolution ? K_COARSE : K_FINE;
  // extension phase spans 32 prescale units per count step
  assign unit_target = ext_phase ? {tcount, 5'h00} :
    {3'h0, protocol_timer.period} + 8'h01;
  assign start_evt = start_timer_command |
    (timer_source_select & iframe_unacked & ~unacked_q);
  assign stop_evt = timer_write |
    (timer_source_select & ~iframe_unacked);
  assign expiry = timer_running && tx_tick &&
    prescale == k_factor - 16'h0001 &&
    units == unit_target - 8'h01;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unacked_q <= 1'b0;
    end else begin
      unacked_q <= iframe_unacked;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_running <= 1'b0;
      ext_phase <= 1'b0;
      prescale <= 16'h0000;
      units <= 8'h00;
      retries <= 3'h0;
      timer_irq <= 1'b0;
      supervisory_request <= 1'b0;
      retry_exhausted <= 1'b0;
    end else begin
      timer_irq <= 1'b0;
      supervisory_request <= 1'b0;
      retry_exhausted <= 1'b0;
      if (stop_evt) begin
        timer_running <= 1'b0;
      end else if (start_evt) begin
        timer_running <= 1'b1;
        ext_phase <= ~timer_source_select && tcount != 3'h0 &&
          tcount != COUNT_UNLIMITED;
        prescale <= 16'h0000;
        units <= 8'h00;
        retries <= 3'h0;
      end else if (timer_running && tx_tick) begin
        if (prescale == k_factor - 16'h0001) begin
          prescale <= 16'h0000;
          units <= expiry ? 8'h00 : units + 8'h01;
        end else begin
          prescale <= prescale + 16'h0001;
        end
        if (expiry) begin
          if (ext_phase) begin
            ext_phase <= 1'b0;
          end else if (!timer_source_select) begin
            timer_irq <= 1'b1;
            timer_running <= tcount == COUNT_UNLIMITED;
          end else if (tcount == COUNT_UNLIMITED) begin
            supervisory_request <= 1'b1;
          end else if (retries < tcount) begin
            supervisory_request <= 1'b1;
            retries <= retries + 3'h1;
          end else begin
            timer_running <= 1'b0;
            retry_exhausted <= 1'b1;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // fully transparent byte assembly from the data pin
  // ------------------------------------------------------------
  logic [7:0] pin_shift;
  logic [2:0] pin_bits;
  logic [7:0] pin_byte;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_shift <= RESET_BYTE;
      pin_bits <= 3'h0;
      pin_byte <= RESET_BYTE;
    end else if (rx_tick && op_mode == HDTAS_EXT_TRANSP) begin
      pin_shift <= {rx_data_sync[1], pin_shift[7:1]};
      pin_bits <= pin_bits + 3'h1;
      if (pin_bits == 3'h7) begin
        pin_byte <= {rx_data_sync[1], pin_shift[7:1]};
      end
    end
  end

  // ------------------------------------------------------------
  // receive frame tracking
  // ------------------------------------------------------------
  logic [11:0] byte_count;
  logic count_over;
  logic [1:0] high_code;
  logic cr_seen;
  logic low_hit;
  logic lost;
  logic [7:0] early_byte;
  logic [11:0] min_len;
  logic high_byte_now;
  logic low_byte_now;
  logic early_now;
  logic [1:0] next_high_code;
  hdtas_status_type status;
  hdtas_status_type next_status;
  logic [11:0] last_count;
  logic last_over;
  logic framed;
  assign framed = op_mode != HDTAS_EXT_TRANSP;
  // high byte recognition in two-byte modes and transparent mode 1
  assign high_byte_now = byte_count == 12'h000 &&
    ((op_mode != HDTAS_TRANSP && address_width_select) ||
     (op_mode == HDTAS_TRANSP && address_width_select));
  assign low_byte_now = op_mode != HDTAS_TRANSP &&
    byte_count == {11'h000, address_width_select};
  assign early_now = op_mode == HDTAS_TRANSP &&
    byte_count == {11'h000, address_width_select};
  always_comb begin
    if (rx_byte == rx_high_address_first) begin
      next_high_code = MATCH_FIRST;
    end else if (rx_byte == rx_high_address_second) begin
      next_high_code = MATCH_SECOND;
    end else if (rx_byte == GROUP_ADDR_A || rx_byte == GROUP_ADDR_B) begin
      next_high_code = MATCH_GROUP;
    end else begin
      next_high_code = MATCH_NONE;
    end
  end
  always_comb begin
    if (op_mode == HDTAS_TRANSP) begin
      min_len = address_width_select ? MIN_LEN_NARROW :
        MIN_LEN_TRANSP0;
    end else begin
      min_len = address_width_select ? MIN_LEN_WIDE : MIN_LEN_NARROW;
    end
  end
  always_comb begin
    next_status.frame_valid = rx_bits_aligned &&
      byte_count >= min_len;
    next_status.rx_overflow = lost | rx_data_lost;
    next_status.crc_ok = rx_crc_ok;
    next_status.rx_aborted = rx_abort;
    next_status.high_match_code_msb = high_code[1];
    next_status.high_match_code_lsb = high_code[0];
    next_status.cr_bit = cr_seen;
    next_status.low_match = low_hit;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_count <= 12'h000;
      count_over <= 1'b0;
      high_code <= MATCH_NONE;
      cr_seen <= 1'b0;
      low_hit <= 1'b0;
      lost <= 1'b0;
      early_byte <= RESET_BYTE;
      status <= RESET_BYTE;
      last_count <= 12'h000;
      last_over <= 1'b0;
      receive_queue_valid <= 1'b0;
      receive_queue_data <= RESET_BYTE;
    end else begin
      receive_queue_valid <= 1'b0;
      if (rx_data_lost) begin
        lost <= 1'b1;
      end
      if (framed && rx_frame_end) begin
        status <= next_status;
        last_count <= byte_count;
        last_over <= count_over;
        receive_queue_valid <= 1'b1;
        receive_queue_data <= next_status;
        byte_count <= 12'h000;
        count_over <= 1'b0;
        lost <= 1'b0;
        high_code <= MATCH_NONE;
        low_hit <= 1'b0;
      end else if (framed && rx_byte_valid) begin
        receive_queue_valid <= 1'b1;
        receive_queue_data <= rx_byte;
        if (byte_count == COUNT_MAX) begin
          count_over <= 1'b1;
        end else begin
          byte_count <= byte_count + 12'h001;
        end
        if (high_byte_now) begin
          high_code <= next_high_code;
          cr_seen <= rx_byte[1];
        end
        if (low_byte_now) begin
          low_hit <= rx_byte == rx_low_address_first;
        end
        if (early_now) begin
          early_byte <= rx_byte;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read data, captured in the setup phase
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    if (idx == IDX_TIMER) begin
      rd_byte = protocol_timer;
    end else if (idx == IDX_MODE) begin
      rd_byte = mode_reg;
    end else if (idx == IDX_RX_COUNT_LO) begin
      rd_byte = last_count[7:0];
    end else if (idx == IDX_RX_STATUS) begin
      rd_byte = status;
    end else if (idx == IDX_RX_LOW1) begin
      if (op_mode == HDTAS_EXT_TRANSP) begin
        rd_byte = pin_byte;
      end else if (op_mode == HDTAS_TRANSP) begin
        rd_byte = early_byte;
      end else begin
        rd_byte = RESET_BYTE;
      end
    end else if (idx == IDX_RX_COUNT_HI) begin
      rd_byte = {3'h0, last_over, last_count[11:8]};
    end else begin
      rd_byte = RESET_BYTE;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= (hit && !pwrite) ? {24'h00_0000, rd_byte} :
        32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/hdtas_regs_props.sv
// assertions on the ports of the register bank
`timescale 1ns/1ps
`default_nettype none
module hdtas_regs_props (
  input wire logic pclk, // bus clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // byte address
  input wire logic rx_byte_valid, // byte strobe
  input wire logic [7:0] rx_byte, // received byte
  input wire logic rx_frame_end, // frame closed
  input wire logic rx_bits_aligned, // whole bytes
  input wire logic rx_crc_ok, // checksum good
  input wire logic rx_abort, // aborted
  input wire logic timer_irq, // timer pulse
  input wire logic supervisory_request, // retry pulse
  input wire logic retry_exhausted, // retries used up
  input wire logic timer_running, // timer level
  input wire logic receive_queue_valid, // queue strobe
  input wire logic [7:0] receive_queue_data // queue byte
);
  import hdtas_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  queue_copy_a: assert property (
    rx_byte_valid |=> receive_queue_valid &&
    receive_queue_data == $past(rx_byte))
    else $error("received byte not forwarded");
  status_push_a: assert property (
    rx_frame_end |=> receive_queue_valid &&
    receive_queue_data[5] == $past(rx_crc_ok) &&
    receive_queue_data[4] == $past(rx_abort))
    else $error("status byte wrong at frame end");
  misaligned_bad_a: assert property (
    rx_frame_end && !rx_bits_aligned |=> !receive_queue_data[7])
    else $error("misaligned frame marked valid");
  irq_pulse_a: assert property (
    timer_irq |=> !timer_irq)
    else $error("timer pulse longer than one cycle");
  quiet_start_a: assert property (
    $rose(timer_running) |-> (!timer_irq && !supervisory_request) [*8])
    else $error("timer expired right after start");
  retry_stop_a: assert property (
    retry_exhausted |=> !timer_running)
    else $error("timer runs after retries used up");
  write_stop_a: assert property (
    psel && penable && pwrite && paddr[9:2] == IDX_TIMER
    |=> !timer_running)
    else $error("timer write did not stop timer");
  request_running_a: assert property (
    supervisory_request |-> timer_running)
    else $error("retry sent while timer idle");
endmodule
bind hdtas_regs hdtas_regs_props u_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .rx_byte_valid, .rx_byte, .rx_frame_end,
  .rx_bits_aligned, .rx_crc_ok, .rx_abort, .timer_irq,
  .supervisory_request, .retry_exhausted, .timer_running,
  .receive_queue_valid, .receive_queue_data);
`default_nettype wire

// ===== testbench/hdtas_peer.sv
// remote station model: transmit clock and framed receive bytes
`timescale 1ns/1ps
`default_nettype none
module hdtas_peer (
  input wire logic pclk, // bus clock for strobes
  output logic tx_clk_pin, // free running transmit clock
  output logic rx_clk_pin, // receive clock
  output logic rx_data_pin, // receive data, idle mark
  output logic rx_byte_valid, // byte strobe
  output logic [7:0] rx_byte, // received byte
  output logic rx_frame_end, // frame closed
  output logic rx_bits_aligned, // whole bytes
  output logic rx_crc_ok, // checksum good
  output logic rx_abort, // aborted by sender
  output logic rx_data_lost // data dropped
);
  initial begin
    tx_clk_pin = 1'b0;
    rx_clk_pin = 1'b0;
    rx_data_pin = 1'b1;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h5A;
    rx_frame_end = 1'b0;
    rx_bits_aligned = 1'b0;
    rx_crc_ok = 1'b0;
    rx_abort = 1'b0;
    rx_data_lost = 1'b0;
    // odd offset keeps the link clock out of phase with pclk
    #37;
    forever #200 {tx_clk_pin, rx_clk_pin} = ~{tx_clk_pin, rx_clk_pin};
  end
  // f holds {aligned, crc good, aborted, data lost}
  task automatic send_frame(input logic [31:0] w, input int n,
    input logic [3:0] f);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_byte_valid <= 1'b1;
      rx_byte <= w[8*i+:8];
      rx_data_lost <= f[0] && i == 1;
      @(posedge pclk);
      rx_byte_valid <= 1'b0;
      // stale byte is inverted so no match is found by accident
      rx_byte <= ~w[8*i+:8];
      rx_data_lost <= 1'b0;
    end
    @(posedge pclk);
    rx_frame_end <= 1'b1;
    rx_bits_aligned <= f[3];
    rx_crc_ok <= f[2];
    rx_abort <= f[1];
    @(posedge pclk);
    rx_frame_end <= 1'b0;
    rx_bits_aligned <= ~f[3];
    rx_crc_ok <= ~f[2];
    rx_abort <= ~f[1];
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the timer, address and status bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hdtas_pkg::*;
  localparam int T1 = 512 * 8; // t1 in pclk cycles, period 0
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic tx_clk_pin, rx_clk_pin, rx_data_pin, iframe_unacked;
  logic tx_is_command, rx_byte_valid, rx_frame_end, rx_bits_aligned;
  logic rx_crc_ok, rx_abort, rx_data_lost, tx_addr_insert;
  logic modulo_select, command_interpretation, timer_irq;
  logic supervisory_request, retry_exhausted, timer_running;
  logic receive_queue_valid;
  logic [7:0] rx_byte, tx_addr_high, tx_addr_low, receive_queue_data;
  logic [7:0] q[$];
  logic [2:0] ev;
  int err_count, comparisons;
  logic [31:0] fw [5] = '{32'h0000_2148, 32'h0000_23FE, 32'h0000_2144,
    32'h0000_2144, 32'h0000_2144};
  int fn [5] = '{4, 4, 3, 4, 4};
  logic [3:0] ff [5] = '{4'hC, 4'h9, 4'hE, 4'h4, 4'hC};
  logic [7:0] fs [5] = '{8'hA1, 8'hC6, 8'h39, 8'h29, 8'hA9};
  assign ev = {retry_exhausted, supervisory_request, timer_irq};
  hdtas_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_clk_pin, .rx_clk_pin,
    .rx_data_pin, .iframe_unacked, .tx_is_command, .rx_byte_valid,
    .rx_byte, .rx_frame_end, .rx_bits_aligned, .rx_crc_ok, .rx_abort,
    .rx_data_lost, .tx_addr_high, .tx_addr_low, .tx_addr_insert,
    .modulo_select, .command_interpretation, .timer_irq,
    .supervisory_request, .retry_exhausted, .timer_running,
    .receive_queue_valid, .receive_queue_data);
  hdtas_peer u_peer (.pclk, .tx_clk_pin, .rx_clk_pin, .rx_data_pin,
    .rx_byte_valid, .rx_byte, .rx_frame_end, .rx_bits_aligned,
    .rx_crc_ok, .rx_abort, .rx_data_lost);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (receive_queue_valid === 1'b1) q.push_back(receive_queue_data);
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] i,
    input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // waits for one pulse of ev[s]; its delay must lie in lo..hi
  task automatic wait_ev(input int s, input int lo, input int hi);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (ev[s] !== 1'b1 && k < hi + 20);
    check(k >= lo && k <= hi, 1'b1);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    conclude();
  end
  initial begin
    {presetn, psel, penable, pwrite, iframe_unacked} = '0;
    {tx_is_command, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, IDX_TIMER, 0);
    check(d[7:0], RESET_BYTE);
    apb(1, IDX_TIMER, 32'h0000_00E1);
    apb(0, IDX_TIMER, 0);
    check(d[7:0], 8'hE1);
    apb(0, 8'h30, 0);
    check({e, d[30:0]}, {1'b1, 31'h0});
    apb(1, IDX_MODE, 32'h0000_0022);
    apb(1, IDX_TX_ADDR1, 32'h0000_0040);
    apb(1, IDX_TX_ADDR2, 32'h0000_0055);
    apb(1, IDX_RX_HIGH1, 32'h0000_0046);
    tx_is_command <= 1'b1;
    repeat (3) @(posedge pclk);
    check(tx_addr_high, 8'h42);
    check({tx_addr_low, tx_addr_insert}, {8'h55, 1'b1});
    check(command_interpretation, 1'b1);
    tx_is_command <= 1'b0;
    apb(1, IDX_RX_HIGH2, 32'h0000_004A);
    apb(1, IDX_MODE, 32'h0000_0062);
    repeat (3) @(posedge pclk);
    check(tx_addr_high, 8'h40);
    check({modulo_select, tx_addr_insert}, 2'b10);
    $display("register and address test done");
    apb(1, IDX_TIMER, 32'h0000_0001);
    apb(1, IDX_COMMAND, 32'h0000_0010);
    wait_ev(0, 2 * T1 - 16, 2 * T1 + 16);
    repeat (2) @(posedge pclk);
    check(timer_running, 1'b0);
    apb(1, IDX_TIMER, 32'h0000_00E0);
    apb(1, IDX_COMMAND, 32'h0000_0010);
    wait_ev(0, T1 - 16, T1 + 16);
    wait_ev(0, T1 - 2, T1 + 2);
    apb(1, IDX_TIMER, 32'h0000_00E0);
    repeat (2) @(posedge pclk);
    check(timer_running, 1'b0);
    apb(1, IDX_MODE, 32'h0000_0072);
    apb(1, IDX_TIMER, 32'h0000_0020);
    iframe_unacked <= 1'b1;
    wait_ev(1, T1 - 16, T1 + 16);
    wait_ev(2, T1 - 2, T1 + 2);
    iframe_unacked <= 1'b0;
    apb(1, IDX_TIMER, 32'h0000_00E0);
    iframe_unacked <= 1'b1;
    wait_ev(1, T1 - 16, T1 + 16);
    wait_ev(1, T1 - 2, T1 + 2);
    check(timer_running, 1'b1);
    iframe_unacked <= 1'b0;
    repeat (3) @(posedge pclk);
    check(timer_running, 1'b0);
    $display("timer test done");
    apb(1, IDX_MODE, 0);
    apb(1, IDX_RX_HIGH1, 0);
    check({tx_addr_high, tx_addr_low}, 16'h5500);
    apb(1, IDX_MODE, 32'h0000_0060);
    apb(1, IDX_RX_HIGH1, 32'h0000_0044);
    apb(1, IDX_RX_HIGH2, 32'h0000_0048);
    apb(1, IDX_RX_LOW1, 32'h0000_0021);
    apb(1, IDX_RX_LOW2, 32'h0000_0023);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) apb(1, IDX_RX_HIGH2, 32'h0000_0044);
      q.delete();
      u_peer.send_frame(fw[i], fn[i], ff[i]);
      repeat (3) @(posedge pclk);
      check(q.size(), fn[i] + 1);
      check({q[0], q[$]}, {fw[i][7:0], fs[i]});
      apb(0, IDX_RX_STATUS, 0);
      check(d[7:0], fs[i]);
      apb(1, IDX_RX_COUNT_LO, 32'h0000_00FF);
      apb(0, IDX_RX_COUNT_LO, 0);
      check(d[7:0], fn[i]);
    end
    apb(1, IDX_MODE, 32'h0000_0080);
    u_peer.send_frame(32'h4433_2211, 4, 4'hC);
    apb(0, IDX_RX_LOW1, 0);
    check(d[7:0], 8'h11);
    apb(1, IDX_MODE, 32'h0000_00C0);
    repeat (80) @(posedge pclk);
    apb(0, IDX_RX_LOW1, 0);
    check(d[7:0], 8'hFF);
    $display("receive test done");
    conclude();
  end
endmodule
`default_nettype wire
